/* core/ils_pkg.sv */
package ils_pkg;
  localparam int REG_COUNT = 64;
  localparam int REG_W = 6;
  localparam logic [3:0] LAT_INT = 4'h2;
  localparam logic [3:0] LAT_MUL = 4'h5;
  localparam logic [3:0] LAT_LOAD = 4'h5;
  localparam logic [3:0] LAT_FSIMPLE = 4'h3;
  localparam logic [3:0] LAT_FCONV = 4'h5;
  localparam logic [3:0] LAT_FARITH = 4'h7;
  localparam logic [3:0] IVL_ONE = 4'h1;
  localparam logic [3:0] IVL_MUL2 = 4'h2;
  localparam logic [4:0] BUSY_NONE = 5'h00;

  typedef enum logic [4:0] {
    ILS_C_INT = 5'h00,
    ILS_C_BRANCH = 5'h01,
    ILS_C_HILO_MOVE = 5'h02,
    ILS_C_MUL2 = 5'h03,
    ILS_C_MUL1 = 5'h04,
    ILS_C_DIV2 = 5'h05,
    ILS_C_DIV1 = 5'h06,
    ILS_C_LOAD = 5'h07,
    ILS_C_STORE = 5'h08,
    ILS_C_LINKED = 5'h09,
    ILS_C_FSIMPLE = 5'h0A,
    ILS_C_FCONV = 5'h0B,
    ILS_C_FARITH = 5'h0C,
    ILS_C_FDIVSQRT = 5'h0D,
    ILS_C_FCTRL = 5'h0E
  } ils_class_t;

  typedef enum logic [2:0] {
    ILS_U_INT1 = 3'h0,
    ILS_U_INT2 = 3'h1,
    ILS_U_MEM = 3'h2,
    ILS_U_FLT1 = 3'h3,
    ILS_U_FLT2 = 3'h4,
    ILS_U_NONE = 3'h7
  } ils_unit_t;

  typedef struct packed {
    logic valid;
    ils_class_t cls;
    logic multimedia;
    logic [REG_W-1:0] srcA;
    logic [REG_W-1:0] srcB;
    logic [REG_W-1:0] dest;
    logic hasDest;
  } ils_req_t;

  typedef struct packed {
    logic valid;
    ils_unit_t unit;
    logic [3:0] latency;
  } ils_grant_t;

  typedef struct packed {
    logic robOldest;
    logic sysQueueEmpty;
    logic ctrlIdle;
  } ils_env_t;
endpackage

/* core/ils_unit_timer.sv */
`timescale 1ns/1ps
module ils_unit_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] interval,
  output logic free
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = interval - W'(1);
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign free = (count == '0);
endmodule

/* core/ils_scoreboard.sv */
`timescale 1ns/1ps
module ils_scoreboard (
  input wire logic mclk,
  input wire logic arst_n,
  input ils_pkg::ils_req_t req,
  input ils_pkg::ils_env_t env,
  input wire logic intDivDone,
  input wire logic fltDivDone,
  input wire logic [ils_pkg::REG_W-1:0] varDoneReg,
  output ils_pkg::ils_grant_t grant,
  output logic stall
);
  import ils_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][3:0] ready;
    logic [REG_COUNT-1:0] varPending;
    logic mul2Busy;
    logic intDivBusy;
    logic fltDivBusy;
    logic fltRoundRobin;
    logic intRoundRobin;
    ils_grant_t grant;
    logic stall;
  } ils_state_t;

  ils_state_t st;
  ils_state_t next_st;

  logic mul2Free;
  logic mul2Load;
  logic srcBusy;
  ils_unit_t pick;
  logic [3:0] lat;
  logic varOp;
  logic go;
  logic mm;
  logic srcAWait;
  logic srcBWait;

  ils_unit_timer #(.W(4)) mulTimer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(mul2Load),
    .interval(IVL_MUL2),
    .free(mul2Free)
  );

  // Unit choice and latency per class
  always_comb begin
    pick = ILS_U_NONE;
    lat = 4'h0;
    varOp = 1'b0;
    mm = req.multimedia;
    unique case (req.cls)
      ILS_C_INT, ILS_C_HILO_MOVE: begin
        pick = st.intRoundRobin ? ILS_U_INT2 : ILS_U_INT1;
        lat = LAT_INT;
      end
      ILS_C_BRANCH: begin
        pick = ILS_U_INT1;
        lat = LAT_INT;
      end
      ILS_C_MUL2: begin
        if (mul2Free && !st.intDivBusy) begin
          pick = ILS_U_INT2;
        end
        lat = LAT_MUL;
      end
      ILS_C_MUL1: begin
        if (!st.intDivBusy) begin
          pick = ILS_U_INT2;
        end
        lat = LAT_MUL;
      end
      ILS_C_DIV2, ILS_C_DIV1: begin
        if (!st.intDivBusy && mul2Free) begin
          pick = ILS_U_INT2;
        end
        varOp = 1'b1;
      end
      ILS_C_LOAD: begin
        pick = ILS_U_MEM;
        lat = LAT_LOAD;
      end
      ILS_C_STORE: begin
        pick = ILS_U_MEM;
      end
      ILS_C_LINKED: begin
        // Skips the memory interval, waits at queue head
        if (env.robOldest && env.sysQueueEmpty) begin
          pick = ILS_U_MEM;
        end
        lat = LAT_LOAD;
      end
      ILS_C_FSIMPLE: begin
        pick = ILS_U_FLT1;
        lat = LAT_FSIMPLE;
      end
      ILS_C_FCONV: begin
        pick = ILS_U_FLT1;
        lat = LAT_FCONV;
      end
      ILS_C_FARITH: begin
        // Unit two skipped while its divider is busy
        pick = (st.fltRoundRobin && !st.fltDivBusy) ? ILS_U_FLT2
                                                    : ILS_U_FLT1;
        lat = LAT_FARITH;
      end
      ILS_C_FDIVSQRT: begin
        if (!st.fltDivBusy) begin
          pick = ILS_U_FLT2;
        end
        varOp = 1'b1;
      end
      ILS_C_FCTRL: begin
        // Serialised on the memory port behind older work
        if (env.ctrlIdle && env.robOldest) begin
          pick = ILS_U_MEM;
        end
        lat = LAT_INT;
      end
      default: begin
        pick = ILS_U_NONE;
      end
    endcase
  end

  // Count starts at the latency; a consumer goes once it reads 2
  assign srcAWait = st.ready[req.srcA] > 4'h2 || st.varPending[req.srcA];
  assign srcBWait = st.ready[req.srcB] > 4'h2 || st.varPending[req.srcB];
  assign srcBusy = req.valid && (srcAWait || srcBWait);

  assign go = req.valid && !srcBusy && (pick != ILS_U_NONE);
  assign mul2Load = go && (req.cls == ILS_C_MUL2);

  // Countdown, busy flags and registered answer
  always_comb begin
    next_st = st;
    next_st.mul2Busy = !mul2Free;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (st.ready[i] != 4'h0) begin
        next_st.ready[i] = st.ready[i] - 4'h1;
      end
    end
    // Done clears first so a same-cycle issue wins
    if (intDivDone) begin
      next_st.intDivBusy = 1'b0;
    end
    if (fltDivDone) begin
      next_st.fltDivBusy = 1'b0;
    end
    if (intDivDone || fltDivDone) begin
      next_st.varPending[varDoneReg] = 1'b0;
    end
    next_st.grant.valid = go;
    next_st.grant.unit = go ? pick : ILS_U_NONE;
    next_st.grant.latency = go ? lat : 4'h0;
    next_st.stall = req.valid && !go;

    if (go) begin
      if (pick == ILS_U_INT1 || pick == ILS_U_INT2) begin
        next_st.intRoundRobin = !st.intRoundRobin;
      end
      if (req.cls == ILS_C_FARITH) begin
        next_st.fltRoundRobin = !st.fltRoundRobin;
      end
      if (req.cls == ILS_C_DIV1 || req.cls == ILS_C_DIV2) begin
        next_st.intDivBusy = 1'b1;
      end
      if (req.cls == ILS_C_FDIVSQRT) begin
        next_st.fltDivBusy = 1'b1;
      end
      if (req.hasDest) begin
        if (varOp) begin
          next_st.varPending[req.dest] = 1'b1;
          next_st.ready[req.dest] = 4'h0;
        end else begin
          next_st.ready[req.dest] = lat;
          next_st.varPending[req.dest] = 1'b0;
        end
      end
    end
    if (mm) begin
      next_st.stall = next_st.stall;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle answer shows no unit
      st <= '0;
      st.grant.unit <= ILS_U_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign grant = st.grant;
  assign stall = st.stall;
endmodule

/* testbench/ils_scoreboard_chk.sv */
`timescale 1ns/1ps
module ils_scoreboard_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input ils_pkg::ils_req_t req,
  input ils_pkg::ils_env_t env,
  input ils_pkg::ils_grant_t grant,
  input wire logic stall
);
  import ils_pkg::*;
  ils_class_t pc;
  ils_env_t pe;
  // Class and environment seen at the request edge
  always_ff @(posedge mclk) begin
    pc <= req.cls;
    pe <= env;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_answer_next: assert property (
    req.valid |=> grant.valid ^ stall) else $error("no answer");
  a_branch_unit: assert property (
    grant.valid && pc == ILS_C_BRANCH |-> grant.unit == ILS_U_INT1)
    else $error("branch unit");
  a_muldiv_unit: assert property (
    grant.valid && pc inside {ILS_C_MUL1, ILS_C_MUL2, ILS_C_DIV1,
    ILS_C_DIV2} |-> grant.unit == ILS_U_INT2) else $error("muldiv unit");
  a_fsimple_lat: assert property (
    grant.valid && pc == ILS_C_FSIMPLE |-> grant.unit == ILS_U_FLT1 &&
    grant.latency == 4'h3) else $error("fsimple");
  a_fconv_lat: assert property (
    grant.valid && pc == ILS_C_FCONV |-> grant.unit == ILS_U_FLT1 &&
    grant.latency == 4'h5) else $error("fconv");
  a_farith_lat: assert property (
    grant.valid && pc == ILS_C_FARITH |-> grant.latency == 4'h7 &&
    grant.unit inside {ILS_U_FLT1, ILS_U_FLT2}) else $error("farith");
  a_mul2_gap: assert property (
    grant.valid && pc == ILS_C_MUL2 |=> !(grant.valid &&
    pc == ILS_C_MUL2)) else $error("mul2 gap");
  a_linked_wait: assert property (
    grant.valid && pc == ILS_C_LINKED |-> pe.robOldest &&
    pe.sysQueueEmpty) else $error("linked early");
endmodule
bind ils_scoreboard ils_scoreboard_chk chk (
  .mclk(mclk),
  .arst_n(arst_n),
  .req(req),
  .env(env),
  .grant(grant),
  .stall(stall)
);

/* testbench/ils_div_model.sv */
`timescale 1ns/1ps
module ils_div_model #(parameter int DLY = 6) (
  input wire logic mclk,
  input wire logic arst_n,
  input ils_pkg::ils_req_t req,
  input ils_pkg::ils_grant_t grant,
  output logic intDivDone,
  output logic fltDivDone,
  output logic [ils_pkg::REG_W-1:0] varDoneReg
);
  import ils_pkg::*;
  logic [REG_W-1:0] last, dst;
  logic flt;
  int cnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      intDivDone <= 0;
      fltDivDone <= 0;
      varDoneReg <= '0;
    end else begin
      last <= req.dest;
      intDivDone <= cnt == 1 && !flt;
      fltDivDone <= cnt == 1 && flt;
      // Register lines toggle when no result is offered
      varDoneReg <= cnt == 1 ? dst : ~varDoneReg;
      if (cnt > 0) cnt <= cnt - 1;
      if (grant.valid && grant.latency == 0 && grant.unit != ILS_U_MEM) begin
        cnt <= DLY;
        dst <= last;
        flt <= grant.unit == ILS_U_FLT2;
      end
    end
  end
endmodule

/* testbench/test_issue_latency_scoreboard.sv */
`timescale 1ns/1ps
module test_issue_latency_scoreboard;
  import ils_pkg::*;
  logic mclk = 0, arst_n = 0, mm = 0, intDivDone, fltDivDone, stall;
  logic [REG_W-1:0] varDoneReg;
  ils_req_t req = '0;
  ils_env_t env = 3'h7;
  ils_grant_t grant;
  int n_fail = 0, total_checks = 0, cyc = 0, st;
  always #4 mclk = ~mclk;
  ils_scoreboard dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .req(req),
    .env(env),
    .intDivDone(intDivDone),
    .fltDivDone(fltDivDone),
    .varDoneReg(varDoneReg),
    .grant(grant),
    .stall(stall)
  );
  ils_div_model #(.DLY(6)) far (
    .mclk(mclk),
    .arst_n(arst_n),
    .req(req),
    .grant(grant),
    .intDivDone(intDivDone),
    .fltDivDone(fltDivDone),
    .varDoneReg(varDoneReg)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(input ils_class_t c, input logic [5:0] s, d);
    req = '{1'b1, c, mm, s, s, d, 1'b1};
    st = 0;
    do begin
      @(posedge mclk);
      #1;
      if (stall === 1'b1) st++;
    end while (grant.valid !== 1'b1 && st < 100);
  endtask
  task automatic hold(input ils_class_t c, input ils_env_t e);
    env = e;
    req = '{1'b1, c, mm, 6'h1, 6'h1, 6'h2, 1'b1};
    repeat (3) begin
      @(posedge mclk);
      #1;
      chk(stall, 1);
    end
    env = 3'h7;
    issue(c, 1, 2);
    chk(st, 0);
  endtask
  task automatic t_table();
    ils_class_t tc[9] = '{ILS_C_INT, ILS_C_BRANCH, ILS_C_HILO_MOVE,
      ILS_C_MUL1, ILS_C_LOAD, ILS_C_FSIMPLE, ILS_C_FCONV, ILS_C_FARITH,
      ILS_C_STORE};
    logic [3:0] tl[9] = '{2, 2, 2, 5, 5, 3, 5, 7, 0};
    for (int m = 0; m < 2; m++) begin
      mm = m[0];
      for (int i = 0; i < 9; i++) begin
        issue(tc[i], 1, 2);
        chk(grant.latency, tl[i]);
        chk(st, 0);
      end
    end
    $display("table done");
  endtask
  task automatic t_dep();
    issue(ILS_C_INT, 1, 5);
    issue(ILS_C_INT, 5, 6);
    chk(st, 0);
    issue(ILS_C_FARITH, 6, 7);
    issue(ILS_C_FARITH, 7, 8);
    chk(st, 5);
    issue(ILS_C_MUL2, 1, 3);
    issue(ILS_C_MUL2, 1, 4);
    chk(st, 1);
    hold(ILS_C_LINKED, 3'h3);
    hold(ILS_C_LINKED, 3'h5);
    hold(ILS_C_FCTRL, 3'h6);
    $display("dependency done");
  endtask
  task automatic t_div();
    issue(ILS_C_DIV1, 1, 9);
    chk(grant.unit, ILS_U_INT2);
    issue(ILS_C_DIV2, 1, 10);
    chk(st > 0 && st < 100, 1);
    issue(ILS_C_INT, 10, 11);
    chk(st > 0 && st < 100, 1);
    issue(ILS_C_FDIVSQRT, 1, 12);
    chk(grant.unit, ILS_U_FLT2);
    issue(ILS_C_FARITH, 1, 13);
    chk(grant.unit, ILS_U_FLT1);
    issue(ILS_C_INT, 12, 14);
    chk(st > 0 && st < 100, 1);
    req.valid = 0;
    $display("divide done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1;
    t_table();
    t_dep();
    t_div();
    end_sim();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_sim();
    end
  end
endmodule
